// file: rtl/pattern_output_pkg.sv
// Constants and helpers for the pattern output trigger and mode block
// How it works
// - Group 1 trigger select at bits 3:2: 00 ch0, 01 ch1, 1x ch2; resets 11
// - Group 0 trigger select at bits 1:0, same encoding, resets to 11
// - Mode register is 8 bits; bit n picks non-overlap mode for group n
// - Mode register loads F0 on reset and on hardware standby
// - Registers keep their contents through software standby
// - Mode bits 7:4 ignore writes and always read as one
// - Mode bit 0: group updates only on compare A of its channel
// - Mode bit 1: group updates on both compare A and compare B
// - Enabled bits copy next data to port data on trigger; others hold
// - Non-overlap: compare A copies all bits, compare B only zero bits
`default_nettype none
package pattern_output_pkg;
  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NUM_GRP = 4;
  localparam int GRP_W = 4;
  localparam int NUM_CH = 3;
  localparam int SEL_W = 2;
  localparam int DATA_W = NUM_GRP * GRP_W;
  localparam int APB_ADDR_W = 8;
  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [APB_ADDR_W-1:0] OFS_TRIG_SEL = 8'h00;
  localparam logic [APB_ADDR_W-1:0] OFS_MODE = 8'h04;
  localparam logic [APB_ADDR_W-1:0] OFS_NEXT_DATA = 8'h08;
  localparam logic [APB_ADDR_W-1:0] OFS_NEXT_ENABLE = 8'h0C;
  localparam logic [APB_ADDR_W-1:0] OFS_PORT_DATA = 8'h10;
  // ****************************************************************
  // Reset values and fields
  // ****************************************************************
  localparam logic [7:0] TRIG_SEL_RESET = 8'hFF;
  localparam logic [7:0] MODE_RESET = 8'hF0;
  localparam logic [3:0] MODE_RSVD = MODE_RESET[7:4];
  localparam logic [3:0] MODE_BITS_RESET = MODE_RESET[3:0];
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
  localparam logic [SEL_W-1:0] SEL_CH0 = 2'h0;
  localparam logic [SEL_W-1:0] SEL_CH1 = 2'h1;

  // Channel event picked by a group's select field; 10 and 11 both mean ch2
  function automatic logic chan_pick(input logic [NUM_CH-1:0] ev,
                                     input logic [SEL_W-1:0] sel);
    if (sel == SEL_CH0) begin
      return ev[0];
    end else if (sel == SEL_CH1) begin
      return ev[1];
    end
    return ev[2];
  endfunction
endpackage
`default_nettype wire

// file: rtl/pattern_group_load.sv
// Per-group trigger decode: which port data bits copy next data this cycle
`default_nettype none
`timescale 1ns/100ps
module pattern_group_load (
  input wire logic [pattern_output_pkg::SEL_W-1:0] trig_sel_i,
  input wire logic nonoverlap_i,
  input wire logic [pattern_output_pkg::NUM_CH-1:0] cmp_a_i,
  input wire logic [pattern_output_pkg::NUM_CH-1:0] cmp_b_i,
  input wire logic [pattern_output_pkg::GRP_W-1:0] next_data_i,
  input wire logic [pattern_output_pkg::GRP_W-1:0] enable_i,
  output logic [pattern_output_pkg::GRP_W-1:0] copy_mask_o,
  output logic load_o
);
  import pattern_output_pkg::*;
  // ****************************************************************
  // Trigger decode
  // ****************************************************************
  logic hit_a;
  logic hit_b;
  // Strobes are used raw, so a pulse loads in the cycle it appears
  assign hit_a = chan_pick(cmp_a_i, trig_sel_i);
  // Compare B is blind in normal mode
  assign hit_b = nonoverlap_i & chan_pick(cmp_b_i, trig_sel_i);
  // Compare A takes every bit, compare B only bits heading to zero
  assign copy_mask_o = enable_i & ({GRP_W{hit_a}} |
                       ({GRP_W{hit_b}} & ~next_data_i));
  assign load_o = hit_a | hit_b;
endmodule // pattern_group_load
`default_nettype wire

// file: rtl/pattern_output_trigger_mode.sv
// Pattern output trigger select, output mode and port data update, APB slave
//
// Our own choices: the address map and the APB register port.
`default_nettype none
`timescale 1ns/100ps
module pattern_output_trigger_mode (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic hw_standby_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [pattern_output_pkg::APB_ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [pattern_output_pkg::NUM_CH-1:0] cmp_a_i,
  input wire logic [pattern_output_pkg::NUM_CH-1:0] cmp_b_i,
  output logic [pattern_output_pkg::DATA_W-1:0] port_data_o,
  output logic [pattern_output_pkg::NUM_GRP-1:0] grp_load_o
);
  import pattern_output_pkg::*;

  // ****************************************************************
  // Standby pin synchroniser
  // ****************************************************************
  logic stby_meta;
  logic stby_sync;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      stby_meta <= 1'b0;
      stby_sync <= 1'b0;
    end else begin
      stby_meta <= hw_standby_i;
      stby_sync <= stby_meta;
    end
  end

  // ****************************************************************
  // Registers and bus decode
  // ****************************************************************
  logic [7:0] trig_sel;
  logic [NUM_GRP-1:0] mode_bits;
  logic [DATA_W-1:0] next_data;
  logic [DATA_W-1:0] next_enable;
  logic [DATA_W-1:0] port_data;
  logic [31:0] prdata;
  logic [DATA_W-1:0] copy_mask;
  logic [DATA_W-1:0] next_port_data;
  logic [31:0] rd_value;
  logic init;
  logic wr_en;
  logic rd_setup;
  logic hit_any;
  logic wr_port;

  // Hardware standby clears exactly like reset; software standby has no pin
  assign init = rst_i | stby_sync;
  assign wr_en = psel_i & penable_i & pwrite_i;
  assign rd_setup = psel_i & ~penable_i & ~pwrite_i;
  assign hit_any = (paddr_i == OFS_TRIG_SEL) | (paddr_i == OFS_MODE) |
                   (paddr_i == OFS_NEXT_DATA) | (paddr_i == OFS_NEXT_ENABLE) |
                   (paddr_i == OFS_PORT_DATA);
  assign wr_port = wr_en & (paddr_i == OFS_PORT_DATA);
  // Zero wait states: read data is captured in the setup cycle
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~hit_any;
  assign prdata_o = prdata;
  assign port_data_o = port_data;

  // Read mux; reserved mode bits always read as one
  assign rd_value =
    (paddr_i == OFS_TRIG_SEL) ? {24'h0000_00, trig_sel} :
    (paddr_i == OFS_MODE) ? {24'h0000_00, MODE_RSVD, mode_bits} :
    (paddr_i == OFS_NEXT_DATA) ? {16'h0000, next_data} :
    (paddr_i == OFS_NEXT_ENABLE) ? {16'h0000, next_enable} :
    (paddr_i == OFS_PORT_DATA) ? {16'h0000, port_data} : 32'h0000_0000;

  // Trigger copy beats a software write to the same port bit
  assign next_port_data = ((wr_port ? pwdata_i[DATA_W-1:0] : port_data) &
                          ~copy_mask) | (next_data & copy_mask);

  // ****************************************************************
  // Per-group trigger decode
  // ****************************************************************
  for (genvar g = 0; g < NUM_GRP; g++) begin : grp
    pattern_group_load u_load (
      .trig_sel_i(trig_sel[SEL_W*g +: SEL_W]),
      .nonoverlap_i(mode_bits[g]),
      .cmp_a_i(cmp_a_i),
      .cmp_b_i(cmp_b_i),
      .next_data_i(next_data[GRP_W*g +: GRP_W]),
      .enable_i(next_enable[GRP_W*g +: GRP_W]),
      .copy_mask_o(copy_mask[GRP_W*g +: GRP_W]),
      .load_o(grp_load_o[g])
    );
  end

  // Control registers; only reset or hardware standby clear them
  always_ff @(posedge clk_sys_i) begin
    if (init) begin
      trig_sel <= TRIG_SEL_RESET;
      mode_bits <= MODE_BITS_RESET;
      next_data <= DATA_RESET;
      next_enable <= DATA_RESET;
    end else if (wr_en) begin
      if (paddr_i == OFS_TRIG_SEL) trig_sel <= pwdata_i[7:0];
      // Upper mode bits are not stored at all
      if (paddr_i == OFS_MODE) mode_bits <= pwdata_i[3:0];
      if (paddr_i == OFS_NEXT_DATA) next_data <= pwdata_i[DATA_W-1:0];
      if (paddr_i == OFS_NEXT_ENABLE) next_enable <= pwdata_i[DATA_W-1:0];
    end
  end

  // Port data and read capture
  always_ff @(posedge clk_sys_i) begin
    if (init) begin
      port_data <= DATA_RESET;
      prdata <= 32'h0000_0000;
    end else begin
      port_data <= next_port_data;
      if (rd_setup) prdata <= rd_value;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  // Cycles with no bus write and no standby must leave control alone
  logic calm;
  assign calm = ~wr_en & ~stby_sync;

  // Bus side: register contents, reads and standby
  // Standby lands on the control registers exactly like reset
  a_mode_reset_value: assert property (
    stby_sync |=> mode_bits == MODE_BITS_RESET
    && trig_sel == TRIG_SEL_RESET)
    else $error("standby did not restore reset values");
  // The upper nibble is not stored, so only the read path makes the ones
  a_mode_read_ones: assert property (
    rd_setup && paddr_i == OFS_MODE && !stby_sync
    |=> prdata_o[7:4] == 4'hF && prdata_o[3:0] == $past(mode_bits))
    else $error("mode read lost reserved ones");
  // A mode write keeps only the low nibble
  a_mode_write_low: assert property (
    wr_en && paddr_i == OFS_MODE && !stby_sync
    |=> mode_bits == 4'($past(pwdata_i)))
    else $error("mode bits not written");
  // A select write lands whole, all four group fields at once
  a_trig_write: assert property (
    wr_en && paddr_i == OFS_TRIG_SEL && !stby_sync
    |=> trig_sel == 8'($past(pwdata_i)))
    else $error("trigger select not written");
  // Only a write or standby may move the control registers
  a_regs_hold_idle: assert property (
    calm |=> $stable(mode_bits) && $stable(trig_sel))
    else $error("control changed without a write");
  // Read data stands until the next read setup
  a_prdata_hold: assert property (
    !rd_setup && !stby_sync |=> $stable(prdata_o))
    else $error("read data moved outside a read");
  // Standby is seen two edges after the pin, the price of the synchroniser
  a_sync_delay: assert property (
    $rose(stby_sync) |-> $past(hw_standby_i, 2))
    else $error("standby seen without two-stage delay");

  // Trigger side: selection, modes and copies into port data
  // Group 1 on channel 0 copies its next data on compare A
  a_grp1_ch0_load: assert property (
    trig_sel[3:2] == SEL_CH0 && cmp_a_i[0] && next_enable[7:4] == 4'hF
    && !stby_sync |=> port_data_o[7:4] == $past(next_data[7:4]))
    else $error("group 1 missed channel 0 trigger");
  // Both 1x codes pick channel 2 for group 0
  a_grp0_ch2_load: assert property (
    trig_sel[1] && cmp_a_i[2] && next_enable[3:0] == 4'hF && !stby_sync
    |=> port_data_o[3:0] == $past(next_data[3:0]))
    else $error("group 0 missed channel 2 trigger");
  // Group 3 on channel 2 copies enabled bits the same way
  a_grp3_ch2_load: assert property (
    trig_sel[7] && cmp_a_i[2] && next_enable[15:12] == 4'hF && !stby_sync
    |=> port_data_o[15:12] == $past(next_data[15:12]))
    else $error("group 3 missed channel 2 trigger");
  // A normal group ignores compare B entirely
  a_normal_ignore_b: assert property (
    !mode_bits[0] && cmp_a_i == 3'h0 && !wr_port && !stby_sync
    |=> $stable(port_data_o[3:0]))
    else $error("normal group moved without compare A");
  // No compare A and a normal group raises no load strobe
  a_normal_no_load: assert property (
    !mode_bits[2] && cmp_a_i == 3'h0 |-> !grp_load_o[2])
    else $error("normal group loaded on compare B");
  // Non-overlap compare A copies every enabled bit, ones included
  a_nonov_a_all: assert property (
    mode_bits[1] && trig_sel[3:2] == SEL_CH1 && cmp_a_i[1]
    && next_enable[7:4] == 4'hF && !stby_sync
    |=> port_data_o[7:4] == $past(next_data[7:4]))
    else $error("compare A skipped a bit");
  // Non-overlap compare B may only pull bits low
  a_nonov_b_zeros: assert property (
    mode_bits[1] && cmp_a_i == 3'h0 && cmp_b_i[1]
    && trig_sel[3:2] == SEL_CH1 && next_enable[7:4] == 4'hF
    && !wr_port && !stby_sync |=> port_data_o[7:4] ==
    ($past(port_data_o[7:4]) & $past(next_data[7:4])))
    else $error("compare B copied a one");
  // Disabled bits never follow next data
  a_disabled_hold: assert property (
    next_enable[3:0] == 4'h0 && !wr_port && !stby_sync
    |=> $stable(port_data_o[3:0]))
    else $error("disabled bits changed");
  // Strobes are used raw, so the load shows in the strobe's own cycle
  a_same_cycle_load: assert property (
    cmp_a_i[2] && trig_sel[1] |-> grp_load_o[0])
    else $error("load strobe not in strobe cycle");
  // Same for the top group on channel 1
  a_grp3_ch1_strobe: assert property (
    trig_sel[7:6] == SEL_CH1 && cmp_a_i[1] |-> grp_load_o[3])
    else $error("group 3 missed channel 1 strobe");

  // Main scenarios the bench should reach
  c_normal_load: cover property (!mode_bits[1] && grp_load_o[1]);
  c_nonov_b_load: cover property (mode_bits[0] && cmp_b_i != 3'h0
    && grp_load_o[0] && cmp_a_i == 3'h0);
  c_bad_address: cover property (pslverr_o);
  c_standby_init: cover property (stby_sync);
  c_ch2_spare_code: cover property (trig_sel[1:0] == 2'h2 && grp_load_o[0]);
endmodule // pattern_output_trigger_mode
`default_nettype wire

// file: testbench/timer_strobe_model.sv
// Model of three timer channels giving compare A and B strobes
`default_nettype none
`timescale 1ns/100ps
module timer_strobe_model #(
  parameter int PERIOD = 7,
  parameter int MARGIN = 3
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [2:0] run_i,
  output logic [2:0] cmp_a_o,
  output logic [2:0] cmp_b_o
);
  int cnt;
  // Counter cleared by compare B; one-cycle strobes only while running
  // Idle count parks at the margin so compare B leads compare A
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || run_i == 3'h0) begin
      cnt <= MARGIN;
      cmp_a_o <= 3'h0;
      cmp_b_o <= 3'h0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      cmp_b_o <= (cnt == PERIOD - 1) ? run_i : 3'h0;
      cmp_a_o <= (cnt == MARGIN - 1) ? run_i : 3'h0;
    end
  end
endmodule // timer_strobe_model
`default_nettype wire

// file: testbench/tb_pattern_output_trigger_mode.sv
// Self-checking bench for the pattern trigger and mode block
`default_nettype none
`timescale 1ns/100ps
module tb_pattern_output_trigger_mode;
  import pattern_output_pkg::*;
  typedef struct {
    logic [7:0] sel;
    logic [3:0] mode;
    logic [15:0] nd;
    logic [15:0] en;
    logic [2:0] run;
    logic [15:0] fin;
  } row_s;
  // Row: select, mode, next data, enable, running channels, final port
  row_s rows[6] = '{'{8'h00, 4'h0, 16'hA5A5, 16'hFFFF, 3'h1, 16'hA5A5},
    '{8'h55, 4'hF, 16'h0F0F, 16'hFFFF, 3'h2, 16'h0F0F},
    '{8'hAA, 4'h0, 16'h1234, 16'h00FF, 3'h4, 16'hED34},
    '{8'hFF, 4'h5, 16'hC3C3, 16'hF0F0, 3'h4, 16'hCCCC},
    '{8'h00, 4'h0, 16'hFFFF, 16'hFFFF, 3'h2, 16'h0000},
    '{8'hE4, 4'hA, 16'h9669, 16'hFFFF, 3'h7, 16'h9669}};
  row_s cur;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic hw_standby_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [2:0] run = 3'h0;
  logic chk_on = 1'b0;
  logic [31:0] prdata_o, rdv;
  logic pready_o, pslverr_o, err;
  logic [2:0] cmp_a, cmp_b;
  logic [15:0] port_data_o, exp_pd, next_pd;
  logic [3:0] grp_load_o, exp_ld;
  int n_mismatch = 0;
  int tests_run = 0;
  pattern_output_trigger_mode pattern_output_trigger_mode_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .hw_standby_i(hw_standby_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .cmp_a_i(cmp_a),
    .cmp_b_i(cmp_b), .port_data_o(port_data_o), .grp_load_o(grp_load_o));
  timer_strobe_model timer_strobe_model_inst (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .run_i(run), .cmp_a_o(cmp_a), .cmp_b_o(cmp_b));
  // ****
  // Tasks
  // ****
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer; an idle edge first so psel never toggles twice
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do @(posedge clk_sys_i); while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdv, err);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000, rdv, err);
    chk($sformatf("reg_%h", a), e, rdv);
  endtask
  // Expected loads and next port data from the strobes seen now
  task automatic ref_step;
    int c;
    next_pd = exp_pd;
    for (int g = 0; g < 4; g++) begin
      c = cur.sel[2*g+1] ? 2 : int'(cur.sel[2*g]);
      exp_ld[g] = cmp_a[c] | (cmp_b[c] & cur.mode[g]);
      for (int k = 4 * g; k < 4 * g + 4; k++) begin
        if (cur.en[k] && cmp_a[c]) next_pd[k] = cur.nd[k];
        else if (cur.en[k] && exp_ld[g] && !cur.nd[k]) next_pd[k] = 1'b0;
      end
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ****
  // Processes
  // ****
  initial begin
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  // Watchdog sized well past the whole sequence
  initial begin
    repeat (3000) @(posedge clk_sys_i);
    n_mismatch++;
    report_and_stop();
  end
  // Checked on the falling edge, where strobes and outputs are settled
  always @(negedge clk_sys_i) begin
    if (chk_on) begin
      ref_step();
      chk("port_data", {16'h0000, exp_pd}, {16'h0000, port_data_o});
      chk("grp_load", {28'h0, exp_ld}, {28'h0, grp_load_o});
      exp_pd = next_pd;
    end
  end
  initial begin
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rd_chk(OFS_TRIG_SEL, 32'h0000_00FF);
    rd_chk(OFS_MODE, 32'h0000_00F0);
    foreach (rows[i]) begin
      cur = rows[i];
      wr(OFS_TRIG_SEL, {24'h0, cur.sel});
      wr(OFS_MODE, {28'h0, cur.mode});
      wr(OFS_NEXT_DATA, {16'h0000, cur.nd});
      wr(OFS_NEXT_ENABLE, {16'h0000, cur.en});
      wr(OFS_PORT_DATA, {16'h0000, ~cur.nd});
      rd_chk(OFS_MODE, {24'h0, 4'hF, cur.mode});
      rd_chk(OFS_TRIG_SEL, {24'h0, cur.sel});
      exp_pd = ~cur.nd;
      chk_on <= 1'b1;
      run <= cur.run;
      repeat (16) @(posedge clk_sys_i);
      run <= 3'h0;
      repeat (2) @(posedge clk_sys_i);
      chk_on <= 1'b0;
      rd_chk(OFS_PORT_DATA, {16'h0000, cur.fin});
    end
    // Unmapped address is refused and reads zero
    apb(1'b0, 8'h20, 32'h0000_0000, rdv, err);
    chk("slverr", 32'h0000_0001, {31'h0, err});
    chk("unmapped", 32'h0000_0000, rdv);
    wr(OFS_MODE, 32'h0000_000F);
    wr(OFS_TRIG_SEL, 32'h0000_0000);
    repeat (10) @(posedge clk_sys_i);
    rd_chk(OFS_MODE, 32'h0000_00FF);
    hw_standby_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    hw_standby_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    rd_chk(OFS_MODE, 32'h0000_00F0);
    rd_chk(OFS_TRIG_SEL, 32'h0000_00FF);
    report_and_stop();
  end
endmodule // tb_pattern_output_trigger_mode
`default_nettype wire
